// ### rtl/tmr_cmp_pkg.sv
// Purpose: constants for the reload and compare value block
// Assumes: 32-bit AHB-Lite register bus, word-aligned registers
// Notes: control word and status word sit at offsets of this block's own
package tmr_cmp_pkg;
  localparam logic [7:0] off_reload = 8'h2c;
  localparam logic [7:0] off_ch1 = 8'h34;
  localparam logic [7:0] off_ch2 = 8'h38;
  localparam logic [7:0] off_ch3 = 8'h3c;
  localparam logic [7:0] off_ctrl = 8'h50;
  localparam logic [7:0] off_status = 8'h54;
  // control word fields
  localparam int ctrl_wide_bit = 0;
  localparam int ctrl_update_bit = 1;
  localparam int ctrl_preload_lsb = 4;
  localparam int ctrl_enable_lsb = 8;
  localparam int ctrl_dir_lsb = 12;
  localparam logic [31:0] value_reset = 32'h0000_0000;
  localparam logic [1:0] dir_output = 2'h0;
  localparam int num_ch = 3;
  typedef enum logic [1:0] {bus_idle = 2'b00, bus_write = 2'b01, bus_read = 2'b11} bus_state_t;
endpackage

// ### rtl/tmr_chan_if.sv
`timescale 1ns/100ps
// Purpose: groups one channel's controls and results
// Assumes: one instance per channel
// Notes: controls driven by the top, value and wave driven by the channel module
interface tmr_chan_if;
  logic is_output;
  logic preload_en;
  logic chan_en;
  logic wide;
  logic sw_write;
  logic [31:0] sw_data;
  logic update;
  logic capture_in;
  logic [31:0] counter;
  logic [31:0] value;
  logic wave;
  modport top (output is_output, preload_en, chan_en, wide, sw_write, sw_data, update, capture_in, counter,
               input value, wave);
  modport chan (input is_output, preload_en, chan_en, wide, sw_write, sw_data, update, capture_in, counter,
                output value, wave);
endinterface

// ### rtl/tmr_chan.sv
`timescale 1ns/100ps
// Purpose: one capture/compare channel: preload, active compare, capture
// Assumes: capture_in is synchronous to hclk
// Notes: capture fires on rising edge of capture_in
module tmr_chan (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // channel group
  tmr_chan_if.chan c
);
  logic [31:0] preload_r;
  logic [31:0] active_r;
  logic cap_d_r;
  logic wave_r;
  logic [31:0] wdata;

  // upper half is dropped unless wide counting is on
  assign wdata = c.wide ? c.sw_data : {16'h0000, c.sw_data[15:0]};

  // preload value, shown to software; capture overwrites it in input mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      preload_r <= tmr_cmp_pkg::value_reset;
    end else if (!c.is_output && c.chan_en && c.capture_in && !cap_d_r) begin
      preload_r <= c.wide ? c.counter : {16'h0000, c.counter[15:0]};
    end else if (c.sw_write) begin
      preload_r <= wdata;
    end
  end

  // active compare register: at once without preload, on update with it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_r <= tmr_cmp_pkg::value_reset;
    end else if (c.is_output && c.sw_write && !c.preload_en) begin
      active_r <= wdata;
    end else if (c.is_output && c.update && c.preload_en) begin
      active_r <= preload_r;
    end
  end

  // edge detect history and compare result
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_d_r <= 1'b0;
      wave_r <= 1'b0;
    end else begin
      cap_d_r <= c.capture_in;
      wave_r <= c.is_output && c.chan_en && (c.counter < active_r);
    end
  end

  assign c.value = preload_r;
  assign c.wave = wave_r;
endmodule

// ### rtl/tmr_cmp_top.sv
`timescale 1ns/100ps
// Purpose: reload and compare value registers of a general timer
// Assumes: AHB-Lite single word transfers, inputs synchronous to hclk
// Notes: writes take effect at the data-phase edge; one wait state on reads

// Contract
// - the reload register is a preload feeding a separate active reload register.
// - the counter holds still while the active reload value is zero.
// - the reload value is 32 bits only on wide-capable instances with wide counting on.
// - channel values are 32 bits on wide-capable instances with wide counting on, else 16.
// - with preload off, an output channel write goes to the active compare at once.
// - with preload on, the written value reaches the active compare on an update event.
// - each channel picks preload or immediate from its own preload enable bit.
// - each enabled output channel compares its active value with the counter to make its waveform; other channels hold their waveform low.
// - an input channel's value register returns the counter caught at its last capture or the value last written by software, whichever came later.
// - direction field 00 means output compare, any other value means capture input; ch2's field is not stored, so ch2 is always output compare.
// - capture happens only while the channel enable bit is set.
module tmr_cmp_top #(
  parameter bit wide_capable = 1'b1
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // timer side
  input wire logic update_event,
  input wire logic ch1_capture_input,
  input wire logic ch2_capture_input,
  input wire logic ch3_capture_input,
  output logic [31:0] running_counter,
  output logic ch1_wave_out,
  output logic ch2_wave_out,
  output logic ch3_wave_out
);
  tmr_chan_if ch [tmr_cmp_pkg::num_ch] ();

  tmr_cmp_pkg::bus_state_t state_r;
  logic [7:0] addr_r;
  logic [31:0] reload_pre_r;
  logic [31:0] reload_act_r;
  logic [31:0] ctrl_r;
  logic [31:0] cnt_r;
  logic [31:0] rdata_r;
  logic wide;
  logic wr_en;
  logic [31:0] ch_value [tmr_cmp_pkg::num_ch];
  logic [tmr_cmp_pkg::num_ch-1:0] wave;
  logic [tmr_cmp_pkg::num_ch-1:0] cap_in;
  logic [31:0] wdata_trim;
  logic sw_update;

  // channel number for a given offset, num_ch if none
  function automatic logic [1:0] chan_of(input logic [7:0] a);
    case (a)
      tmr_cmp_pkg::off_ch1: chan_of = 2'h0;
      tmr_cmp_pkg::off_ch2: chan_of = 2'h1;
      tmr_cmp_pkg::off_ch3: chan_of = 2'h2;
      default: chan_of = 2'h3;
    endcase
  endfunction

  // direction field of a channel, output when 00
  function automatic logic is_out(input logic [31:0] ctl, input int n);
    is_out = ctl[tmr_cmp_pkg::ctrl_dir_lsb + 2*n +: 2] == tmr_cmp_pkg::dir_output;
  endfunction

  assign wide = wide_capable && ctrl_r[tmr_cmp_pkg::ctrl_wide_bit];
  assign wr_en = state_r == tmr_cmp_pkg::bus_write;
  assign wdata_trim = wide ? hwdata : {16'h0000, hwdata[15:0]};
  assign sw_update = wr_en && addr_r == tmr_cmp_pkg::off_ctrl && hwdata[tmr_cmp_pkg::ctrl_update_bit];
  assign cap_in = {ch3_capture_input, ch2_capture_input, ch1_capture_input};

  // per-channel wiring
  for (genvar i = 0; i < tmr_cmp_pkg::num_ch; i++) begin : g_ch
    assign ch[i].is_output = is_out(ctrl_r, i);
    assign ch[i].preload_en = ctrl_r[tmr_cmp_pkg::ctrl_preload_lsb + i];
    assign ch[i].chan_en = ctrl_r[tmr_cmp_pkg::ctrl_enable_lsb + i];
    assign ch[i].wide = wide;
    assign ch[i].sw_write = wr_en && chan_of(addr_r) == 2'(i);
    assign ch[i].sw_data = hwdata;
    assign ch[i].update = update_event || sw_update;
    assign ch[i].capture_in = cap_in[i];
    assign ch[i].counter = cnt_r;
    assign ch_value[i] = ch[i].value;
    assign wave[i] = ch[i].wave;
    tmr_chan u_chan (
      .hclk(hclk),
      .hresetn(hresetn),
      .c(ch[i])
    );
  end

  // bus phase tracker: remembers the address phase for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= tmr_cmp_pkg::bus_idle;
      addr_r <= 8'h00;
    end else if (hready) begin
      addr_r <= haddr[7:0];
      case ({hsel && htrans[1], hwrite})
        2'b11: state_r <= tmr_cmp_pkg::bus_write;
        2'b10: state_r <= tmr_cmp_pkg::bus_read;
        default: state_r <= tmr_cmp_pkg::bus_idle;
      endcase
    end
  end

  // ready is low for one cycle on reads so read data come from a register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hreadyout <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      // load only at the end of the wait state, so read data stand until the next read
      if (!hreadyout) begin
        hrdata <= rdata_r;
      end
    end
  end

  // read mux for the pending address phase
  always_comb begin
    rdata_r = 32'h0000_0000;
    case (addr_r)
      tmr_cmp_pkg::off_reload: rdata_r = reload_pre_r;
      tmr_cmp_pkg::off_ch1: rdata_r = ch_value[0];
      tmr_cmp_pkg::off_ch2: rdata_r = ch_value[1];
      tmr_cmp_pkg::off_ch3: rdata_r = ch_value[2];
      tmr_cmp_pkg::off_ctrl: rdata_r = ctrl_r & 32'h0003_3f71;
      tmr_cmp_pkg::off_status: rdata_r = {28'h0000000, reload_act_r == 32'h0, wave};
      default: rdata_r = 32'h0000_0000;
    endcase
  end

  // control word; update bit is a strobe and is not stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= 32'h0000_0000;
    end else if (wr_en && addr_r == tmr_cmp_pkg::off_ctrl) begin
      ctrl_r <= hwdata & 32'h0003_3f71; // ch1 and ch3 direction fields are kept; ch2's field (bits 15:14) is dropped
    end
  end

  // reload preload, moved to the active reload only on an update
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reload_pre_r <= tmr_cmp_pkg::value_reset;
      reload_act_r <= tmr_cmp_pkg::value_reset;
    end else begin
      if (wr_en && addr_r == tmr_cmp_pkg::off_reload) begin
        reload_pre_r <= wdata_trim;
      end
      if (update_event || sw_update) begin
        reload_act_r <= reload_pre_r;
      end
    end
  end

  // minimal up counter so compare and capture have a reference
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 32'h0000_0000;
    end else if (reload_act_r == 32'h0000_0000) begin
      cnt_r <= cnt_r; // stopped while reload is zero
    end else if (cnt_r >= reload_act_r) begin
      cnt_r <= 32'h0000_0000;
    end else begin
      cnt_r <= wide ? cnt_r + 32'h1 : {16'h0000, cnt_r[15:0] + 16'h1};
    end
  end

  // registered outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      running_counter <= 32'h0000_0000;
      {ch3_wave_out, ch2_wave_out, ch1_wave_out} <= 3'h0;
    end else begin
      running_counter <= cnt_r;
      {ch3_wave_out, ch2_wave_out, ch1_wave_out} <= wave;
    end
  end

  // response is always okay; kept in a flop so every output is registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end
endmodule

// ### testbench/tmr_cmp_asserts.sv
// Purpose: port-level checks for the reload and compare block
// Assumes: hready is the slave's own hreadyout
// Notes: one clock domain, so default clocking and disable are used
`timescale 1ns/100ps
module tmr_cmp_asserts (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // timer side
  input wire logic [31:0] running_counter
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // a taken read, a taken write, and the read's one wait state
  sequence s_rd;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence s_wr;
    hsel && hready && htrans[1] && hwrite;
  endsequence
  sequence s_rd_ans;
    !hreadyout ##1 hreadyout;
  endsequence
  a_read_wait: assert property (s_rd |=> s_rd_ans) else $error("read answer timing wrong");
  a_write_nowait: assert property (s_wr |=> hreadyout) else $error("write was stalled");
  a_stall_cause: assert property (!hreadyout |-> $past(hsel && hready && htrans[1] && !hwrite))
    else $error("stall without a read");
  a_ready_one: assert property (!hreadyout |=> hreadyout) else $error("stall longer than one cycle");
  a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
  a_data_stands: assert property ($stable(hrdata) || !$past(hreadyout)) else $error("read data moved");
  // the counter only holds, steps by one or restarts from zero
  a_count_step: assert property ($stable(running_counter) || running_counter == 32'h0 ||
    running_counter == $past(running_counter) + 32'h1) else $error("counter jumped");
  a_wrap_zero: assert property (running_counter < $past(running_counter) |-> running_counter == 32'h0)
    else $error("counter wrapped to nonzero");
endmodule
bind tmr_cmp_top tmr_cmp_asserts u_tmr_cmp_asserts (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
  .hrdata, .hreadyout, .hresp, .running_counter);

// ### testbench/tb.sv
// Purpose: self-checking bench for the reload and compare block
// Assumes: hready is the slave's own hreadyout
// Notes: a small reload keeps the compare scenario short
`timescale 1ns/100ps
module tb;
  localparam logic [7:0] ch1_a = tmr_cmp_pkg::off_ch1;
  localparam logic [7:0] ch2_a = tmr_cmp_pkg::off_ch2;
  localparam logic [7:0] ch3_a = tmr_cmp_pkg::off_ch3;
  localparam logic [7:0] ctrl_a = tmr_cmp_pkg::off_ctrl;
  localparam logic [7:0] stat_a = tmr_cmp_pkg::off_status;
  localparam logic [7:0] regs [4] = '{tmr_cmp_pkg::off_reload, ch1_a, ch2_a, ch3_a};
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, upd = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, cnt, q, d;
  logic [31:0] cmp [3];
  logic [1:0] htrans = 2'h0;
  logic [2:0] cap = 3'h0, wave;
  int err_count = 0, tests_run = 0, cyc = 0;
  tmr_cmp_top u_tmr_cmp_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .update_event(upd), .ch1_capture_input(cap[0]),
    .ch2_capture_input(cap[1]), .ch3_capture_input(cap[2]), .running_counter(cnt),
    .ch1_wave_out(wave[0]), .ch2_wave_out(wave[1]), .ch3_wave_out(wave[2]));
  initial forever #25 hclk = ~hclk;
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one word transfer; each phase is held until hreadyout is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check($sformatf("register %h", a), q, exp);
  endtask
  task automatic pulse_update();
    @(posedge hclk) upd <= 1'b1;
    @(posedge hclk) upd <= 1'b0;
  endtask
  // the wave pin trails the counter copy by one cycle, so compare against the previous count
  task automatic wave_chk();
    logic [31:0] p;
    repeat (2) @(negedge hclk);
    p = cnt;
    repeat (25) begin
      @(negedge hclk);
      for (int i = 0; i < 3; i++) check("wave", {31'h0, wave[i]}, {31'h0, p < cmp[i]});
      p = cnt;
    end
  endtask
  // a hang is cut short here and counted as a mismatch
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(32'h704bdc0a));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rd(ch2_a, 32'h0);
    rd(stat_a, 32'h8);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, 32'h0);
    $display("done: reset and unmapped");
    // capture while a zero reload holds the counter at zero
    wr(ch1_a, 32'h1234);
    wr(ch2_a, 32'h55);
    wr(ch3_a, 32'h66);
    wr(ctrl_a, 32'h5500);
    @(posedge hclk) cap <= 3'h7;
    @(posedge hclk) cap <= 3'h0;
    check("counter", cnt, 32'h0);
    rd(ch1_a, 32'h0);
    rd(ch2_a, 32'h55);
    rd(ch3_a, 32'h66);
    $display("done: capture");
    // upper half dropped without wide counting, kept with it
    for (int m = 0; m < 2; m++) begin
      wr(ctrl_a, {31'h0, m[0]});
      for (int i = 0; i < 4; i++) begin
        d = $urandom();
        wr(regs[i], d);
        rd(regs[i], m[0] ? d : {16'h0, d[15:0]});
      end
    end
    rd(stat_a, 32'h8);
    $display("done: widths");
    // ch2 preloaded, ch1 and ch3 immediate
    wr(ctrl_a, 32'h720);
    wr(tmr_cmp_pkg::off_reload, 32'h9);
    wr(ch1_a, 32'h4);
    wr(ch2_a, 32'h2);
    wr(ch3_a, 32'h7);
    pulse_update();
    wr(ch2_a, 32'h6);
    cmp = '{32'h4, 32'h2, 32'h7};
    wave_chk();
    pulse_update();
    cmp[1] = 32'h6;
    wave_chk();
    $display("done: compare");
    print_verdict();
  end
endmodule
